// File: logic/cisq_pkg.sv
// Shared constants and types of the card interface sequencer.
// Assumes a single 25 MHz system clock and a 32-bit Avalon-MM register port.
package cisq_pkg;

    // ==================================================================
    // Clock and timing
    // ==================================================================
    localparam int unsigned CLK_PERIOD_NS = 40;         // 25 MHz system clock
    localparam int unsigned UV_TIME_NS = 5000;          // Supply under-range limit, 5 us
    localparam int unsigned MISMATCH_TIME_NS = 4000;    // Clock/reset mismatch limit, 4 us
    localparam int unsigned DEBOUNCE_TIME_MS = 40;      // Card switch debounce, 40 ms
    // Least times round up to whole cycles
    localparam int unsigned UV_CYCLES = (UV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned MISMATCH_CYCLES = (MISMATCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DEBOUNCE_CYCLES =
        (DEBOUNCE_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SYNC_DEPTH = 2;             // Flops in each input synchroniser
    localparam int unsigned ECHO_DELAY = 3;             // Host level to sensed card pin, in cycles
    localparam int unsigned NUM_LANES = 3;              // Data, auxiliary a, auxiliary b

    // ==================================================================
    // Register map (byte addresses)
    // ==================================================================
    localparam logic [3:0] REG_CTRL_ADDR = 4'h0;
    localparam logic [3:0] REG_STATUS_ADDR = 4'h4;

    // Control register fields
    localparam int unsigned CTRL_ACTIVATE_N_BIT = 0;
    localparam int unsigned CTRL_CHANNEL_SELECT_N_BIT = 1;
    localparam int unsigned CTRL_SUPPLY_LEVEL_SEL_BIT = 2;
    localparam int unsigned CTRL_SWITCH_POLARITY_SEL_BIT = 3;
    localparam logic [3:0] CTRL_RESET_VALUE = 4'h3;     // Inactive, channels deselected

    // Status register fields
    localparam int unsigned STAT_STATE_LSB = 0;         // Two bits
    localparam int unsigned STAT_READY_BIT = 2;
    localparam int unsigned STAT_ALARM_BIT = 3;
    localparam int unsigned STAT_PRESENT_BIT = 4;
    localparam int unsigned STAT_LEVEL_BIT = 5;
    localparam int unsigned STAT_DIR_LSB = 6;           // Two bits per lane

    // ==================================================================
    // Types
    // ==================================================================
    typedef enum logic [1:0] {
        CISQ_IDLE = 2'b00,
        CISQ_ACTIVE = 2'b01,
        CISQ_ALARM = 2'b10
    } cisq_state_e;

    typedef enum logic [1:0] {
        CISQ_REST = 2'b00,      // Both sides high, no direction
        CISQ_HOST_IN = 2'b01,   // Host side is input, card side driven
        CISQ_CARD_IN = 2'b10    // Card side is input, host side driven
    } cisq_dir_e;

endpackage

// File: logic/cisq_sequencer.sv
// Card interface sequencer: supply state machine, clock/reset gating, fault checks,
// presence debounce and three half-duplex open-drain channels.
// Assumes external pull-ups on every channel pin and an analog supply with
// under-range and final-value comparator outputs.
//
// Summary of operation
// - Activate low enters Active, enables supply
// - Clock and reset pass only once ready
// - Channels enabled after ready, gated by select
// - Latch supply level at activate falling edge
// - Disabled channels in Active: card lines high, host hi-Z
// - Early select still waits for supply ready
// - Select never touches supply, clock, reset
// - Polarity select chooses active card switch level
// - Card present always shown as low flag
// - Supply under-range 5 us gives Alarm
// - Idle and Alarm discharge card supply
// - Idle grounds card data; relay after ready
// - Rest high; first low side is input
// - Never relay output side back to input
// - Input release returns channel to rest
// - Lingering output-side low not fed back
// - Direction chosen only from both-high rest
// - Auxiliary lines behave like data line
// - Idle drives card reset low; follow later
// - Reset mismatch after ready gives Alarm
// - Idle drives card clock low; pass later
// - Clock mismatch after ready is a fault
// - Alarm left only when activate returns high
// - Presence flag after 40 ms steady switch
// - Alarm output low while in Alarm
// - Supply ready low at final supply value
//
// Our own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps

module cisq_sequencer
    import cisq_pkg::*;
#(
    parameter int unsigned DEBOUNCE_CYC = DEBOUNCE_CYCLES
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // Avalon-MM register port
    input wire logic [3:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    // Card supply generator
    input wire logic i_supply_low,
    input wire logic i_supply_final,
    output logic o_supply_enable,
    output logic o_supply_level,
    output logic o_supply_discharge,
    // Host status pins
    output logic o_supply_ready_n,
    output logic o_alarm_n,
    output logic o_presence_flag_n,
    // Card switch
    input wire logic i_card_switch_in,
    // Clock and reset channels
    input wire logic i_host_clock_in,
    input wire logic i_host_reset_in,
    input wire logic i_card_clock_sense,
    input wire logic i_card_reset_sense,
    output logic o_card_clock,
    output logic o_card_reset,
    // Host-side channels: [0] data, [1] auxiliary a, [2] auxiliary b
    input wire logic [2:0] i_host_chan,
    output logic [2:0] o_host_chan,
    output logic [2:0] o_host_chan_oe_n,
    // Card-side channels: [0] card_data_line, [1] aux line a, [2] aux line b
    input wire logic [2:0] i_card_chan,
    output logic [2:0] o_card_chan,
    output logic [2:0] o_card_chan_oe_n
);

    // Every check below samples the system clock and sleeps through reset
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);

    // ==================================================================
    // Input synchronisers
    // ==================================================================
    localparam int unsigned NSYNC = 13;
    localparam int unsigned DEB_W = $clog2(DEBOUNCE_CYC + 1);

    logic [NSYNC-1:0] raw_in;       // Pin levels as they arrive
    logic [NSYNC-1:0] sync1_ff;     // First stage, read only by second stage
    logic [NSYNC-1:0] sync2_ff;     // Safe levels for the rest of the block
    logic sw_s, uvlow_s, final_s, hclk_s, hrst_s, cclk_s, crst_s;
    logic [2:0] hchan_s, cchan_s;

    assign raw_in = {i_card_chan, i_host_chan, i_card_reset_sense, i_card_clock_sense,
                     i_host_reset_in, i_host_clock_in, i_supply_final, i_supply_low, i_card_switch_in};
    assign {cchan_s, hchan_s, crst_s, cclk_s, hrst_s, hclk_s, final_s, uvlow_s, sw_s} = sync2_ff;

    // Two flops per pin; switch and channel pins reset high, supply flags and clock/reset pins low
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            sync1_ff <= 13'h1F81;
            sync2_ff <= 13'h1F81;
        end else begin
            sync1_ff <= raw_in;
            sync2_ff <= sync1_ff;
        end
    end

    // ==================================================================
    // Register port
    // ==================================================================
    logic [3:0] ctrl_ff, nxt_ctrl;          // Software control bits
    logic wait_ff, nxt_wait;                // Wait request, high while idle
    logic [31:0] rdata_ff, nxt_rdata;
    logic req;
    logic act_n, cs_n, lvl_sel, pol_sel;
    logic [31:0] status_word;

    assign req = i_read | i_write;
    assign act_n = ctrl_ff[CTRL_ACTIVATE_N_BIT];
    assign cs_n = ctrl_ff[CTRL_CHANNEL_SELECT_N_BIT];
    assign lvl_sel = ctrl_ff[CTRL_SUPPLY_LEVEL_SEL_BIT];
    assign pol_sel = ctrl_ff[CTRL_SWITCH_POLARITY_SEL_BIT];

    // One wait cycle per access; write lands on the edge that sees wait low
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_wait = !(req && wait_ff);
        nxt_rdata = rdata_ff;
        if (req && wait_ff) begin
            // Read data prepared during the wait cycle
            case (i_address)
                REG_CTRL_ADDR: nxt_rdata = {28'h0000000, ctrl_ff};
                REG_STATUS_ADDR: nxt_rdata = status_word;
                default: nxt_rdata = 32'h00000000;
            endcase
        end
        if (i_write && !wait_ff && i_address == REG_CTRL_ADDR && i_byteenable[0]) begin
            nxt_ctrl = i_writedata[3:0];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            ctrl_ff <= CTRL_RESET_VALUE;
            wait_ff <= 1'b1;
            rdata_ff <= 32'h00000000;
        end else begin
            ctrl_ff <= nxt_ctrl;
            wait_ff <= nxt_wait;
            rdata_ff <= nxt_rdata;
        end
    end

    assign o_waitrequest = wait_ff;
    assign o_readdata = rdata_ff;

    // ==================================================================
    // Supply state machine and fault checks
    // ==================================================================
    cisq_state_e state_ff, nxt_state;
    logic act_prev_ff, nxt_act_prev;        // For the activate falling edge
    logic level_ff, nxt_level;              // Latched supply level
    logic ready_n_ff, nxt_ready_n;
    logic alarm_n_ff, nxt_alarm_n;
    logic en_ff, nxt_en, dis_ff, nxt_dis;
    logic [7:0] uv_cnt_ff, nxt_uv_cnt;
    logic [7:0] clk_mis_ff, nxt_clk_mis;
    logic [7:0] rst_mis_ff, nxt_rst_mis;
    logic [ECHO_DELAY-1:0] hclk_dly_ff, hrst_dly_ff;
    logic cclk_ff, nxt_cclk, crst_ff, nxt_crst;
    logic pass, chan_live;
    logic uv_fault, clk_fault, rst_fault;

    // Clock/reset and channels follow only with supply ready; select gates channels only
    assign pass = (state_ff == CISQ_ACTIVE) && !ready_n_ff;
    assign chan_live = pass && !cs_n;
    assign uv_fault = uvlow_s && (uv_cnt_ff == 8'(UV_CYCLES - 1));
    // The sensed pin lags the host input by the output flop plus the synchroniser
    assign clk_fault = pass && (cclk_s != hclk_dly_ff[ECHO_DELAY-1]) &&
                       (clk_mis_ff == 8'(MISMATCH_CYCLES - 1));
    assign rst_fault = pass && (crst_s != hrst_dly_ff[ECHO_DELAY-1]) &&
                       (rst_mis_ff == 8'(MISMATCH_CYCLES - 1));

    always_comb begin
        nxt_state = state_ff;
        nxt_act_prev = act_n;
        nxt_level = level_ff;
        // Latch the level only on the activate falling edge
        if (act_prev_ff && !act_n) begin
            nxt_level = lvl_sel;
        end
        case (state_ff)
            CISQ_IDLE: begin
                if (!act_n) begin
                    nxt_state = CISQ_ACTIVE;
                end
            end
            CISQ_ACTIVE: begin
                if (act_n) begin
                    nxt_state = CISQ_IDLE;
                end else if (uv_fault || clk_fault || rst_fault) begin
                    nxt_state = CISQ_ALARM;
                end
            end
            CISQ_ALARM: begin
                if (act_n) begin
                    nxt_state = CISQ_IDLE;
                end
            end
            default: nxt_state = CISQ_IDLE;
        endcase
        // Under-range counted through the whole Active period
        nxt_uv_cnt = (state_ff == CISQ_ACTIVE && uvlow_s && !uv_fault) ? uv_cnt_ff + 8'h01 : 8'h00;
        nxt_clk_mis = (pass && cclk_s != hclk_dly_ff[ECHO_DELAY-1] && !clk_fault) ? clk_mis_ff + 8'h01 : 8'h00;
        nxt_rst_mis = (pass && crst_s != hrst_dly_ff[ECHO_DELAY-1] && !rst_fault) ? rst_mis_ff + 8'h01 : 8'h00;
        // Ready stays low from the final value until Active is left
        nxt_ready_n = !((nxt_state == CISQ_ACTIVE) && (!ready_n_ff || final_s));
        nxt_alarm_n = (nxt_state != CISQ_ALARM);
        nxt_en = (nxt_state == CISQ_ACTIVE);
        nxt_dis = (nxt_state != CISQ_ACTIVE);
        nxt_cclk = pass ? hclk_s : 1'b0;
        nxt_crst = pass ? hrst_s : 1'b0;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            state_ff <= CISQ_IDLE;
            act_prev_ff <= 1'b1;
            level_ff <= 1'b0;
            ready_n_ff <= 1'b1;
            alarm_n_ff <= 1'b1;
            en_ff <= 1'b0;
            dis_ff <= 1'b1;
            uv_cnt_ff <= 8'h00;
            clk_mis_ff <= 8'h00;
            rst_mis_ff <= 8'h00;
            hclk_dly_ff <= '0;
            hrst_dly_ff <= '0;
            cclk_ff <= 1'b0;
            crst_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            act_prev_ff <= nxt_act_prev;
            level_ff <= nxt_level;
            ready_n_ff <= nxt_ready_n;
            alarm_n_ff <= nxt_alarm_n;
            en_ff <= nxt_en;
            dis_ff <= nxt_dis;
            uv_cnt_ff <= nxt_uv_cnt;
            clk_mis_ff <= nxt_clk_mis;
            rst_mis_ff <= nxt_rst_mis;
            hclk_dly_ff <= {hclk_dly_ff[ECHO_DELAY-2:0], hclk_s};
            hrst_dly_ff <= {hrst_dly_ff[ECHO_DELAY-2:0], hrst_s};
            cclk_ff <= nxt_cclk;
            crst_ff <= nxt_crst;
        end
    end

    assign o_supply_enable = en_ff;
    assign o_supply_level = level_ff;
    assign o_supply_discharge = dis_ff;
    assign o_supply_ready_n = ready_n_ff;
    assign o_alarm_n = alarm_n_ff;
    assign o_card_clock = cclk_ff;
    assign o_card_reset = crst_ff;

    // ==================================================================
    // Card presence debounce
    // ==================================================================
    logic present;
    logic [DEB_W-1:0] deb_cnt_ff, nxt_deb_cnt;
    logic card_switch_in_n_ff, nxt_card_switch_in_n;

    assign present = pol_sel ? sw_s : !sw_s;

    // Any absent sample restarts the count; removal shows at once
    always_comb begin
        nxt_deb_cnt = deb_cnt_ff;
        if (!present) begin
            nxt_deb_cnt = '0;
        end else if (deb_cnt_ff != DEB_W'(DEBOUNCE_CYC)) begin
            nxt_deb_cnt = deb_cnt_ff + DEB_W'(1);
        end
        nxt_card_switch_in_n = !(nxt_deb_cnt == DEB_W'(DEBOUNCE_CYC));
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            deb_cnt_ff <= '0;
            card_switch_in_n_ff <= 1'b1;
        end else begin
            deb_cnt_ff <= nxt_deb_cnt;
            card_switch_in_n_ff <= nxt_card_switch_in_n;
        end
    end

    assign o_presence_flag_n = card_switch_in_n_ff;

    // ==================================================================
    // Half-duplex channels, one lane each
    // ==================================================================
    cisq_dir_e dir_ff [NUM_LANES];
    logic [2*NUM_LANES-1:0] dir_bits;
    logic [2:0] hout_ff, hoe_ff, cout_ff, coe_ff;
    logic [2:0] nxt_hout, nxt_hoe, nxt_cout, nxt_coe;

    genvar g;
    generate
        for (g = 0; g < NUM_LANES; g++) begin : g_lane
            cisq_dir_e nxt_dir;

            // Open drain both ways: only lows are ever relayed
            always_comb begin
                nxt_dir = dir_ff[g];
                nxt_hout[g] = 1'b0;
                nxt_hoe[g] = 1'b1;
                nxt_cout[g] = 1'b0;
                nxt_coe[g] = 1'b1;
                if (!chan_live) begin
                    nxt_dir = CISQ_REST;
                    if (state_ff != CISQ_ACTIVE) begin
                        nxt_coe[g] = 1'b0;
                    end else begin
                        nxt_cout[g] = 1'b1;
                        nxt_coe[g] = 1'b0;
                    end
                end else begin
                    case (dir_ff[g])
                        // Host wins a tie; only a rest lane takes a direction
                        CISQ_REST: begin
                            if (!hchan_s[g]) begin
                                nxt_dir = CISQ_HOST_IN;
                            end else if (!cchan_s[g]) begin
                                nxt_dir = CISQ_CARD_IN;
                            end
                        end
                        // Leave only once both sides read high again
                        CISQ_HOST_IN: begin
                            if (hchan_s[g] && cchan_s[g]) begin
                                nxt_dir = CISQ_REST;
                            end
                        end
                        CISQ_CARD_IN: begin
                            if (hchan_s[g] && cchan_s[g]) begin
                                nxt_dir = CISQ_REST;
                            end
                        end
                        default: nxt_dir = CISQ_REST;
                    endcase
                    // Drive only the output side, never back toward the input
                    nxt_coe[g] = !(nxt_dir == CISQ_HOST_IN && !hchan_s[g]);
                    nxt_hoe[g] = !(nxt_dir == CISQ_CARD_IN && !cchan_s[g]);
                end
            end

            always_ff @(posedge i_clk_sys) begin
                if (i_reset) begin
                    dir_ff[g] <= CISQ_REST;
                end else begin
                    dir_ff[g] <= nxt_dir;
                end
            end

            assign dir_bits[2*g+1:2*g] = dir_ff[g];

            // Nothing may flow toward the host side while the host side is the input
            chk_no_backflow: assert property (dir_ff[g] == CISQ_HOST_IN |=>
                (dir_ff[g] != CISQ_HOST_IN) || o_host_chan_oe_n[g])
                else $error("lane drove the host side while host is input");
            chk_dir_from_rest: assert property ((dir_ff[g] != $past(dir_ff[g])) |->
                ($past(dir_ff[g]) == CISQ_REST) || (dir_ff[g] == CISQ_REST))
                else $error("lane direction flipped without passing rest");
            cov_host_to_card: cover property (dir_ff[g] == CISQ_HOST_IN ##[1:50] dir_ff[g] == CISQ_REST);
            cov_card_to_host: cover property (dir_ff[g] == CISQ_CARD_IN ##[1:50] dir_ff[g] == CISQ_REST);
        end
    endgenerate

    // Channel pins all registered together
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            hout_ff <= 3'h0;
            hoe_ff <= 3'h7;
            cout_ff <= 3'h0;
            coe_ff <= 3'h0;
        end else begin
            hout_ff <= nxt_hout;
            hoe_ff <= nxt_hoe;
            cout_ff <= nxt_cout;
            coe_ff <= nxt_coe;
        end
    end

    assign o_host_chan = hout_ff;
    assign o_host_chan_oe_n = hoe_ff;
    assign o_card_chan = cout_ff;
    assign o_card_chan_oe_n = coe_ff;

    assign status_word = {20'h00000, dir_bits, level_ff, !card_switch_in_n_ff, !alarm_n_ff, !ready_n_ff, state_ff};

    // ==================================================================
    // Checks
    // ==================================================================
    chk_enter_active: assert property (state_ff == CISQ_IDLE && !act_n |=>
        state_ff == CISQ_ACTIVE ##0 o_supply_enable && !o_supply_discharge)
        else $error("activate low did not start the supply");
    chk_clock_gated: assert property (!pass |=> !o_card_clock && !o_card_reset)
        else $error("card clock or reset not held low before ready");
    chk_level_hold: assert property (!act_n && !act_prev_ff |=> $stable(o_supply_level))
        else $error("supply level changed while activate low");
    chk_disabled_lines: assert property (state_ff == CISQ_ACTIVE && !chan_live |=>
        o_card_chan == 3'h7 && o_card_chan_oe_n == 3'h0 && o_host_chan_oe_n == 3'h7)
        else $error("disabled channels not parked");
    chk_uv_alarm: assert property (state_ff == CISQ_ACTIVE && !act_n && uv_fault |=>
        state_ff == CISQ_ALARM ##1 !o_alarm_n && o_supply_ready_n)
        else $error("supply under-range did not raise alarm");
    chk_uv_early: assert property ($rose(state_ff == CISQ_ALARM) && $past(uv_cnt_ff) != 8'(UV_CYCLES - 1) |->
        $past(clk_fault) || $past(rst_fault))
        else $error("alarm raised before the under-range time");
    chk_alarm_sticky: assert property (state_ff == CISQ_ALARM && !act_n |=> state_ff == CISQ_ALARM)
        else $error("alarm left while activate low");
    chk_presence: assert property (!present |=> o_presence_flag_n)
        else $error("presence flag low without card");
    chk_bus_answer: assert property (req && wait_ff |=> !o_waitrequest ##1 o_waitrequest)
        else $error("bus answer not one cycle after request");

    cov_ready: cover property (!act_n ##[1:1000] !o_supply_ready_n);
    cov_alarm: cover property ($fell(o_alarm_n));
    cov_present: cover property ($fell(o_presence_flag_n));

endmodule

// File: testbench/cisq_card_model.sv
// Card-side model: pull-ups on the three card lines, a card that can pull any line low.
// Assumes the design's card drive ports; clock is read straight back, reset may be shorted.
`timescale 1ns/1ps
module cisq_card_model (
    // Design drive of the card pins
    input wire logic [2:0] i_out,
    input wire logic [2:0] i_oe_n,
    input wire logic i_clock,
    input wire logic i_card_reset,
    // Card pulls a line low while set
    input wire logic [2:0] i_pull_low,
    // Card shorts its reset contact to ground while set
    input wire logic i_short,
    // Pin levels seen by the design
    output logic [2:0] o_pin,
    output logic o_clock_sense,
    output logic o_reset_sense
);
    // ==========
    // Pins: a released line rests high by its pull-up
    assign o_pin = (i_oe_n | i_out) & ~i_pull_low;
    assign o_clock_sense = i_clock;
    assign o_reset_sense = i_card_reset & ~i_short;
endmodule

// File: testbench/cisq_sequencer_test.sv
// Self-checking bench of the card interface sequencer.
// Assumes the card model on the card pins and pulled-up open-drain host pins.
`timescale 1ns/1ps
module cisq_sequencer_test;
    import cisq_pkg::*;
    // ==========
    // Signals
    logic i_clk_sys = 0, i_reset = 1, i_read = 0, i_write = 0, i_supply_low = 0, i_supply_final = 0;
    logic i_card_switch_in = 1, i_host_clock_in = 0, i_host_reset_in = 0, rst_short = 0;
    logic [3:0] i_address = 0, i_byteenable = 4'hF;
    logic [31:0] i_writedata = 0, rdat;
    logic [2:0] host_drv = 3'h7, card_pull = 3'h0;
    int errors = 0, tests_run = 0;
    wire logic [31:0] o_readdata;
    wire logic o_waitrequest, o_supply_enable, o_supply_level, o_supply_discharge, o_supply_ready_n, o_alarm_n;
    wire logic o_presence_flag_n, o_card_clock, o_card_reset, i_card_clock_sense, i_card_reset_sense;
    wire logic [2:0] o_host_chan, o_host_chan_oe_n, o_card_chan, o_card_chan_oe_n, i_card_chan, i_host_chan;
    // Host pin is wired-AND of host and device
    assign i_host_chan = host_drv & (o_host_chan_oe_n | o_host_chan);
    always #20 i_clk_sys = ~i_clk_sys;
    // Short debounce keeps the run brief
    cisq_sequencer #(.DEBOUNCE_CYC(50)) cisq_sequencer_i (.i_clk_sys, .i_reset, .i_address, .i_read, .i_write,
        .i_writedata, .i_byteenable, .o_readdata, .o_waitrequest, .i_supply_low, .i_supply_final, .o_supply_enable,
        .o_supply_level, .o_supply_discharge, .o_supply_ready_n, .o_alarm_n, .o_presence_flag_n, .i_card_switch_in,
        .i_host_clock_in, .i_host_reset_in, .i_card_clock_sense, .i_card_reset_sense, .o_card_clock, .o_card_reset,
        .i_host_chan, .o_host_chan, .o_host_chan_oe_n, .i_card_chan, .o_card_chan, .o_card_chan_oe_n);
    cisq_card_model cisq_card_model_i (.i_out(o_card_chan), .i_oe_n(o_card_chan_oe_n), .i_clock(o_card_clock),
        .i_card_reset(o_card_reset), .i_pull_low(card_pull), .i_short(rst_short), .o_pin(i_card_chan),
        .o_clock_sense(i_card_clock_sense), .o_reset_sense(i_card_reset_sense));
    // ==========
    // Helpers
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            errors++;
            $display("wrong value %s expected %0h seen %0h", n, e, s);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask
    // One access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        i_address <= a;
        i_writedata <= d;
        i_write <= wr;
        i_read <= ~wr;
        do begin
            @(posedge i_clk_sys);
        end while (o_waitrequest !== 1'b0);
        rdat = o_readdata;
        i_write <= 1'b0;
        i_read <= 1'b0;
        @(posedge i_clk_sys);
    endtask
    // ==========
    // Scenarios
    task automatic t_reset;
        bus(0, REG_CTRL_ADDR, 0);
        chk("ctrl", 32'h3, rdat);
        bus(0, 4'h8, 0);
        chk("unmapped", 32'h0, rdat);
        chk("idle pins", 6'h13, {o_supply_enable, o_supply_discharge, o_card_clock, o_card_reset,
            o_supply_ready_n, o_alarm_n});
        chk("card lines", 3'h0, i_card_chan);
        $display("reset test done");
    endtask
    task automatic t_present;
        bus(1, REG_CTRL_ADDR, 32'hB);
        cyc(40);
        chk("early flag", 1, o_presence_flag_n);
        cyc(30);
        chk("flag high switch", 0, o_presence_flag_n);
        i_card_switch_in <= 1'b0;
        cyc(6);
        chk("flag removed", 1, o_presence_flag_n);
        bus(1, REG_CTRL_ADDR, 32'h3);
        cyc(70);
        chk("flag low switch", 0, o_presence_flag_n);
        $display("presence test done");
    endtask
    task automatic t_active;
        i_host_clock_in <= 1'b1;
        i_host_reset_in <= 1'b1;
        bus(1, REG_CTRL_ADDR, 32'h4);
        cyc(2);
        chk("enable", 1, o_supply_enable);
        bus(1, REG_CTRL_ADDR, 32'h0);
        cyc(8);
        chk("level", 1, o_supply_level);
        chk("gated", 5'h07, {o_card_clock, o_card_reset, o_host_chan_oe_n});
        i_supply_final <= 1'b1;
        cyc(6);
        chk("ready", 3'h3, {o_supply_ready_n, o_card_clock, o_card_reset});
        i_host_clock_in <= 1'b0;
        cyc(5);
        chk("clock follows", 0, o_card_clock);
        bus(0, REG_STATUS_ADDR, 0);
        chk("status", 4'h5, rdat[3:0]);
        $display("activation test done");
    endtask
    task automatic t_lanes;
        host_drv[0] <= 1'b0;
        cyc(5);
        chk("card data low", 0, i_card_chan[0]);
        card_pull[0] <= 1'b1;
        host_drv[0] <= 1'b1;
        cyc(10);
        chk("no echo", 1, i_host_chan[0]);
        card_pull[0] <= 1'b0;
        cyc(8);
        card_pull[1] <= 1'b1;
        cyc(5);
        chk("aux card in", 0, i_host_chan[1]);
        card_pull[1] <= 1'b0;
        cyc(8);
        chk("rest", 6'h3F, {i_host_chan, i_card_chan});
        $display("channel test done");
    endtask
    task automatic t_select;
        bus(1, REG_CTRL_ADDR, 32'h2);
        cyc(4);
        chk("off pins", 6'h3F, {o_host_chan_oe_n, i_card_chan});
        chk("off drive", 6'h38, {o_card_chan, o_card_chan_oe_n});
        chk("select scope", 2'h2, {o_supply_enable, o_supply_ready_n});
        $display("select test done");
    endtask
    task automatic t_alarm;
        i_supply_low <= 1'b1;
        cyc(110);
        chk("short dip", 1, o_alarm_n);
        cyc(30);
        chk("alarm", 3'h3, {o_alarm_n, o_supply_discharge, o_supply_ready_n});
        i_supply_low <= 1'b0;
        i_supply_final <= 1'b0;
        cyc(5);
        chk("alarm held", 0, o_alarm_n);
        bus(1, REG_CTRL_ADDR, 32'h3);
        cyc(3);
        chk("alarm cleared", 2'h3, {o_alarm_n, o_supply_discharge});
        $display("alarm test done");
    endtask
    task automatic t_short;
        i_supply_final <= 1'b1;
        rst_short <= 1'b1;
        bus(1, REG_CTRL_ADDR, 32'h2);
        cyc(60);
        chk("short early", 1, o_alarm_n);
        cyc(50);
        chk("reset short", 2'h1, {o_alarm_n, o_supply_ready_n});
        $display("short test done");
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ==========
    // Main sequence and watchdog
    initial begin
        cyc(10);
        i_reset <= 1'b0;
        t_reset;
        t_present;
        t_active;
        t_lanes;
        t_select;
        t_alarm;
        t_short;
        stop_test;
    end
    initial begin
        #400000;
        errors++;
        stop_test;
    end
endmodule
